// ---- include/ddc_pkg.sv ----
// shared constants and carrier types for the down-converter block
package ddc_pkg;
  // register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] FREQ_OFS = 4'h4;
  localparam logic [3:0] ACTIVE_FREQ_OFS = 4'h8;
  localparam logic [3:0] STATUS_OFS = 4'hC;
  // control field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_REAL_BIT = 1;
  localparam int CTRL_FS4_BIT = 2;
  localparam int CTRL_SWAP_BIT = 3;
  localparam int CTRL_GAIN6_BIT = 4;
  localparam int CTRL_GAIN3_BIT = 5;
  localparam int CTRL_INVERT_BIT = 6;
  localparam int CTRL_ALIGN_EN_BIT = 7;
  localparam int CTRL_RESTART_BIT = 8;
  localparam int CTRL_RES14_BIT = 9;
  localparam int CTRL_DECIM_LSB = 12;
  localparam int CTRL_DECIM_W = 3;
  localparam int CTRL_W = 15;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 15'h1000;
  localparam logic [31:0] FREQ_RESET = 32'h0000_0000;
  // widths
  localparam int SAMPLE_W = 16;
  localparam int ACC_W = 20;
  localparam int COEF_W = 10;
  localparam int CNT_W = 5;
  localparam logic [2:0] DECIM_LOG2_MIN = 3'h1;
  localparam logic [2:0] DECIM_LOG2_MAX = 3'h5;
  localparam logic [1:0] RES14_ZERO_MASK = 2'h3;
  // first quarter of a 16-point sine, amplitude 511
  localparam logic signed [COEF_W-1:0] SIN_TAB [5] = '{
    10'sh000, 10'sh0C4, 10'sh169, 10'sh1D8, 10'sh1FF};
  // quarter-rate rotation phase, gray ordered
  typedef enum logic [1:0] {
    ROT0 = 2'b00,
    ROT1 = 2'b01,
    ROT2 = 2'b11,
    ROT3 = 2'b10
  } rot_t;
  typedef struct packed {
    logic [SAMPLE_W-1:0] a;
    logic [SAMPLE_W-1:0] b;
  } sample_pair_t;
  typedef struct packed {
    logic [SAMPLE_W-1:0] i;
    logic [SAMPLE_W-1:0] q;
  } iq_t;
  typedef struct packed {
    iq_t a;
    iq_t b;
  } ddc_out_t;
endpackage : ddc_pkg

// ---- hdl/down_converter.sv ----
// dual-channel digital down-converter with wishbone register slave
`timescale 1ns/1ps
module down_converter
  import ddc_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // converter samples and alignment pin
  input wire sample_pair_t sample_i,
  input wire logic powerdown_align_pin_i,
  // decimated stream
  output ddc_out_t data_o,
  output logic valid_o
);
  logic [CTRL_W-1:0] ctrl_reg;
  logic [31:0] freq_reg;
  logic [31:0] freq_active_reg;
  logic [31:0] phase_reg;
  logic [CNT_W-1:0] dec_cnt_reg;
  logic restart_evt_reg;
  logic align_pin_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic pending_reg;
  rot_t rot_reg;
  ddc_out_t out_reg;
  logic valid_reg;
  logic [15:0] out_count_reg;

  logic enable, real_mode, fs4_mode, align_evt, dump, second, gain6_on, gain3_on;
  logic [2:0] dec_k;
  logic [CNT_W-1:0] dec_last, half_last;
  logic wb_req, wb_wr;
  logic signed [COEF_W-1:0] cos_c, sin_c;
  logic signed [ACC_W-1:0] res_i [2];
  logic signed [ACC_W-1:0] res_q [2];
  logic [SAMPLE_W-1:0] ch_in [2];

  assign enable = ctrl_reg[CTRL_ENABLE_BIT];
  assign real_mode = ctrl_reg[CTRL_REAL_BIT];
  assign fs4_mode = ctrl_reg[CTRL_FS4_BIT] & ~real_mode;
  // gain selects passed in so the gain stage follows control changes at once
  assign gain6_on = ctrl_reg[CTRL_GAIN6_BIT] & ~real_mode;
  assign gain3_on = ctrl_reg[CTRL_GAIN3_BIT] & real_mode;

  // decimation factor as log2, out-of-range codes clamp to the nearest legal one
  always_comb begin
    dec_k = ctrl_reg[CTRL_DECIM_LSB +: CTRL_DECIM_W];
    if (dec_k < DECIM_LOG2_MIN) begin
      dec_k = DECIM_LOG2_MIN;
    end else if (dec_k > DECIM_LOG2_MAX) begin
      dec_k = DECIM_LOG2_MAX;
    end
  end
  assign dec_last = CNT_W'((6'h01 << dec_k) - 6'h01);
  assign half_last = dec_last >> 1;
  assign dump = (dec_cnt_reg == dec_last);
  assign second = pending_reg & (dec_cnt_reg == half_last) & ~dump;

  // wishbone: one-cycle answer, dropped the cycle after
  assign wb_req = cyc_i & stb_i & ~ack_reg;
  assign wb_wr = wb_req & we_i;

  // alignment when pin rises with alignment enabled, or restart bit toggled
  assign align_evt = restart_evt_reg |
    (ctrl_reg[CTRL_ALIGN_EN_BIT] & powerdown_align_pin_i & ~align_pin_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      align_pin_reg <= 1'b0;
    end else if (ce_i) begin
      align_pin_reg <= powerdown_align_pin_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_reg <= wb_req;
      if (wb_req && !we_i) begin
        case (adr_i)
          CTRL_OFS: dat_reg <= 32'(ctrl_reg);
          FREQ_OFS: dat_reg <= freq_reg;
          ACTIVE_FREQ_OFS: dat_reg <= freq_active_reg;
          STATUS_OFS: dat_reg <= {out_count_reg, 3'h0, pending_reg, rot_reg,
            5'(dec_cnt_reg), 4'h0, enable};
          default: dat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  // control register with restart toggle detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RESET;
      restart_evt_reg <= 1'b0;
    end else if (ce_i) begin
      restart_evt_reg <= 1'b0;
      if (wb_wr && adr_i == CTRL_OFS) begin
        if (sel_i[0]) begin
          ctrl_reg[7:0] <= dat_i[7:0];
        end
        if (sel_i[1]) begin
          ctrl_reg[CTRL_W-1:8] <= dat_i[CTRL_W-1:8];
          restart_evt_reg <= dat_i[CTRL_RESTART_BIT] != ctrl_reg[CTRL_RESTART_BIT];
        end
      end
    end
  end

  // pending frequency word, per byte lane
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_reg <= FREQ_RESET;
    end else if (ce_i && wb_wr && adr_i == FREQ_OFS) begin
      for (int b = 0; b < 4; b++) begin
        if (sel_i[b]) begin
          freq_reg[8*b +: 8] <= dat_i[8*b +: 8];
        end
      end
    end
  end

  // oscillator: a frequency write alone never changes the running frequency
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_active_reg <= FREQ_RESET;
      phase_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      if (align_evt) begin
        freq_active_reg <= freq_reg;
        phase_reg <= 32'h0000_0000;
      end else if (enable && !real_mode) begin
        // signed wrap of the accumulator covers minus to plus half rate
        phase_reg <= phase_reg + freq_active_reg;
      end
    end
  end

  // 16-point sine from a quarter table; top four phase bits address it
  function automatic logic signed [COEF_W-1:0] sin16(input logic [3:0] idx);
    logic [2:0] m;
    logic signed [COEF_W-1:0] mag;
    m = idx[2:0];
    mag = (m <= 3'h4) ? SIN_TAB[m] : SIN_TAB[3'h0 - m];
    sin16 = idx[3] ? -mag : mag;
  endfunction : sin16

  assign cos_c = sin16(phase_reg[31:28] + 4'h4);
  // inverted phase flips the quadrature term, selecting the other image
  assign sin_c = ctrl_reg[CTRL_INVERT_BIT] ? -sin16(phase_reg[31:28]) :
    sin16(phase_reg[31:28]);

  // swap ahead of both filters
  assign ch_in[0] = ctrl_reg[CTRL_SWAP_BIT] ? sample_i.b : sample_i.a;
  assign ch_in[1] = ctrl_reg[CTRL_SWAP_BIT] ? sample_i.a : sample_i.b;

  // decimation divider
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dec_cnt_reg <= '0;
    end else if (ce_i) begin
      if (align_evt || !enable || dump) begin
        dec_cnt_reg <= '0;
      end else begin
        dec_cnt_reg <= dec_cnt_reg + CNT_W'(1);
      end
    end
  end

  // per channel: mixer, accumulate-and-dump filter, gain
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic signed [SAMPLE_W+COEF_W-1:0] prod_i, prod_q;
    logic signed [SAMPLE_W-1:0] mix_i, mix_q;
    logic signed [ACC_W-1:0] acc_i_reg, acc_q_reg, term_i, term_q;
    logic signed [ACC_W-1:0] sum_i, sum_q, full_i, full_q;
    logic [2:0] up;

    assign prod_i = $signed(ch_in[c]) * cos_c;
    assign prod_q = $signed(ch_in[c]) * sin_c;
    // real mode bypasses the mixer and leaves the quadrature path idle
    assign mix_i = real_mode ? $signed(ch_in[c]) : prod_i[SAMPLE_W+COEF_W-2:COEF_W-1];
    assign mix_q = real_mode ? '0 : prod_q[SAMPLE_W+COEF_W-2:COEF_W-1];
    // halved input so 32 summed samples still fit the 20-bit word
    assign term_i = ACC_W'(mix_i >>> 1);
    assign term_q = ACC_W'(mix_q >>> 1);
    assign sum_i = acc_i_reg + term_i;
    assign sum_q = acc_q_reg + term_q;
    assign up = DECIM_LOG2_MAX - dec_k;
    assign full_i = sum_i <<< up;
    assign full_q = sum_q <<< up;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        acc_i_reg <= '0;
        acc_q_reg <= '0;
      end else if (ce_i) begin
        if (align_evt || !enable || dump) begin
          acc_i_reg <= '0;
          acc_q_reg <= '0;
        end else begin
          acc_i_reg <= sum_i;
          acc_q_reg <= sum_q;
        end
      end
    end

    assign res_i[c] = apply_gain(full_i, gain6_on, gain3_on);
    assign res_q[c] = apply_gain(full_q, gain6_on, gain3_on);
  end

  // optional gain with saturation at 20 bits; 3 dB is 1 + 1/4 + 1/8 + 1/32
  function automatic logic signed [ACC_W-1:0] apply_gain(input logic signed [ACC_W-1:0] x,
    input logic g6, input logic g3);
    logic signed [ACC_W+1:0] w;
    w = {{2{x[ACC_W-1]}}, x};
    if (g6) begin
      w = w <<< 1;
    end else if (g3) begin
      w = w + (w >>> 2) + (w >>> 3) + (w >>> 5);
    end
    if (w > $signed({3'b000, {(ACC_W-1){1'b1}}})) begin
      apply_gain = {1'b0, {(ACC_W-1){1'b1}}};
    end else if (w < $signed({3'b111, {(ACC_W-1){1'b0}}})) begin
      apply_gain = {1'b1, {(ACC_W-1){1'b0}}};
    end else begin
      apply_gain = w[ACC_W-1:0];
    end
  endfunction : apply_gain

  // keep the top bits; low bits dropped, two more when 14-bit output is chosen
  function automatic logic [SAMPLE_W-1:0] trunc(input logic signed [ACC_W-1:0] x);
    trunc = x[ACC_W-1:ACC_W-SAMPLE_W];
    if (ctrl_reg[CTRL_RES14_BIT]) begin
      trunc[1:0] = trunc[1:0] & ~RES14_ZERO_MASK;
    end
  endfunction : trunc

  // quarter-rate rotation: real part of (i + jq) times j^n
  function automatic logic signed [ACC_W-1:0] rotate(input rot_t r,
    input logic signed [ACC_W-1:0] i, input logic signed [ACC_W-1:0] q);
    case (r)
      ROT0: rotate = i;
      ROT1: rotate = -q;
      ROT2: rotate = -i;
      ROT3: rotate = q;
      default: rotate = i;
    endcase
  endfunction : rotate

  function automatic rot_t rot_step(input rot_t r);
    case (r)
      ROT0: rot_step = ROT1;
      ROT1: rot_step = ROT2;
      ROT2: rot_step = ROT3;
      ROT3: rot_step = ROT0;
      default: rot_step = ROT0;
    endcase
  endfunction : rot_step

  // the second real sample of a pair is rotated from the held complex result
  logic signed [ACC_W-1:0] held_i_reg [2];
  logic signed [ACC_W-1:0] held_q_reg [2];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rot_reg <= ROT0;
      pending_reg <= 1'b0;
      for (int c = 0; c < 2; c++) begin
        held_i_reg[c] <= '0;
        held_q_reg[c] <= '0;
      end
    end else if (ce_i) begin
      if (align_evt || !enable || !fs4_mode) begin
        rot_reg <= ROT0;
        pending_reg <= 1'b0;
      end else if (dump) begin
        rot_reg <= rot_step(rot_reg);
        pending_reg <= 1'b1;
        for (int c = 0; c < 2; c++) begin
          held_i_reg[c] <= res_i[c];
          held_q_reg[c] <= res_q[c];
        end
      end else if (second) begin
        rot_reg <= rot_step(rot_reg);
        pending_reg <= 1'b0;
      end
    end
  end

  // output stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_reg <= '0;
      valid_reg <= 1'b0;
      out_count_reg <= 16'h0000;
    end else if (ce_i) begin
      valid_reg <= 1'b0;
      if (!enable) begin
        out_reg.a.i <= ch_in[0];
        out_reg.a.q <= '0;
        out_reg.b.i <= ch_in[1];
        out_reg.b.q <= '0;
        valid_reg <= 1'b1;
      end else if (align_evt) begin
        valid_reg <= 1'b0;
      end else if (fs4_mode && (dump || second)) begin
        for (int c = 0; c < 2; c++) begin
          if (c == 0) begin
            out_reg.a.i <= trunc(dump ? rotate(rot_reg, res_i[c], res_q[c]) :
              rotate(rot_reg, held_i_reg[c], held_q_reg[c]));
            out_reg.a.q <= '0;
          end else begin
            out_reg.b.i <= trunc(dump ? rotate(rot_reg, res_i[c], res_q[c]) :
              rotate(rot_reg, held_i_reg[c], held_q_reg[c]));
            out_reg.b.q <= '0;
          end
        end
        valid_reg <= 1'b1;
        out_count_reg <= out_count_reg + 16'h0001;
      end else if (dump) begin
        out_reg.a.i <= trunc(res_i[0]);
        out_reg.a.q <= trunc(res_q[0]);
        out_reg.b.i <= trunc(res_i[1]);
        out_reg.b.q <= trunc(res_q[1]);
        valid_reg <= 1'b1;
        out_count_reg <= out_count_reg + 16'h0001;
      end
    end
  end
  assign data_o = out_reg;
  assign valid_o = valid_reg;
endmodule : down_converter

// ---- bench/ddc_checker_sva.sv ----
// port assertions for the down-converter
`timescale 1ns/1ps
module ddc_checker
  import ddc_pkg::*;
(
  // watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire ddc_out_t data_o,
  input wire logic valid_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_ack_after_req: assert property (cyc_i && stb_i && ce_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  chk_ack_one_cycle: assert property (ack_o && ce_i |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_ack_has_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i && ce_i))
    else $error("ack without request");
  chk_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !valid_o && data_o == '0)
    else $error("outputs not cleared by reset");
  chk_data_holds: assert property ($changed(data_o) |-> valid_o)
    else $error("stream data changed without valid");
  chk_ce_freeze: assert property (!ce_i |=> $stable(ack_o) && $stable(valid_o)
    && $stable(data_o))
    else $error("outputs moved while clock enable low");
  chk_ctrl_upper_zero: assert property (ack_o && !we_i && adr_i == CTRL_OFS
    |-> dat_o[31:CTRL_W] == '0)
    else $error("control readback has stray upper bits");
  chk_unmapped_zero: assert property (ack_o && !we_i && adr_i[1:0] != 2'h0
    |-> dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_read_data_holds: assert property ($changed(dat_o) |-> ack_o && !we_i)
    else $error("read data changed outside a read");
  cover property (valid_o && !$past(valid_o));
  cover property ($rose(ack_o) && we_i);
  cover property (ack_o && !we_i && adr_i[1:0] != 2'h0);
endmodule : ddc_checker

bind down_converter ddc_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
  .ack_o(ack_o), .data_o(data_o), .valid_o(valid_o));

// ---- bench/conv_core_model.sv ----
// converter core model: steady sample levels and a frame-aligned align pin
`timescale 1ns/1ps
module conv_core_model
  import ddc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // stimulus controls
  input wire logic [SAMPLE_W-1:0] level_a_i,
  input wire logic [SAMPLE_W-1:0] level_b_i,
  input wire logic align_req_i,
  // toward the down-converter
  output sample_pair_t sample_o,
  output logic align_o
);
  // reference amplifier stays powered: the model never enters power-down
  logic [5:0] tick_reg;
  always_ff @(posedge clk_i) begin
    tick_reg <= rst_i ? 6'h00 : tick_reg + 6'h01;
  end
  // pin moves only on 64-cycle boundaries so divider phase stays whole
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      align_o <= 1'b0;
    end else if (tick_reg == 6'h00) begin
      align_o <= align_req_i;
    end
  end
  always_ff @(posedge clk_i) begin
    sample_o <= {level_a_i, level_b_i};
  end
endmodule : conv_core_model

// ---- bench/down_converter_test.sv ----
// self-checking bench for the down-converter
`timescale 1ns/1ps
module down_converter_test;
  import ddc_pkg::*;
  logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, valid_o, pin, align_req;
  logic [3:0] adr_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [15:0] lvl_a, lvl_b;
  sample_pair_t sample_i;
  ddc_out_t data_o;
  int failures, comparisons, n;
  down_converter u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .sample_i(sample_i), .powerdown_align_pin_i(pin), .data_o(data_o),
    .valid_o(valid_o));
  conv_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .level_a_i(lvl_a), .level_b_i(lvl_b),
    .align_req_i(align_req), .sample_o(sample_i), .align_o(pin));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // master waits on ack itself; only the bound ends a hang
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      failures++;
      test_done();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic count_valid(input int win);
    n = 0;
    repeat (win) begin
      @(posedge clk_i);
      if (valid_o === 1'b1) n++;
    end
  endtask : count_valid
  task automatic wait_valid;
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (valid_o !== 1'b1 && k < 100);
    if (k >= 100) begin
      failures++;
      test_done();
    end
  endtask : wait_valid
  task automatic t_regs;
    wb(0, CTRL_OFS, 0);
    check(rd, 32'h0000_1000);
    wb(0, FREQ_OFS, 0);
    check(rd, 32'h0000_0000);
    wb(1, ACTIVE_FREQ_OFS, 32'hFFFF_FFFF);
    wb(0, ACTIVE_FREQ_OFS, 0);
    check(rd, 32'h0000_0000);
    wb(0, 4'h2, 0);
    check(rd, 32'h0000_0000);
    wb(0, STATUS_OFS, 0);
    check(rd, 32'h0000_0000);
  endtask : t_regs
  task automatic t_bypass;
    count_valid(16);
    check(n, 16);
    check({data_o.a.i, data_o.b.i}, 32'h0100_FF00);
    check({data_o.a.q, data_o.b.q}, 32'h0000_0000);
    ce_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
  endtask : t_bypass
  task automatic t_retune;
    wb(1, FREQ_OFS, 32'h2762_7627);
    wb(0, ACTIVE_FREQ_OFS, 0);
    check(rd, 32'h0000_0000);
    wb(1, CTRL_OFS, 32'h0000_3101);
    wb(0, ACTIVE_FREQ_OFS, 0);
    check(rd, 32'h2762_7627);
    wb(0, STATUS_OFS, 0);
    check(rd & 32'h0000_0001, 32'h0000_0001);
    wb(1, FREQ_OFS, 32'hD89D_89D9);
    wb(1, CTRL_OFS, 32'h0000_3181);
    wb(0, ACTIVE_FREQ_OFS, 0);
    check(rd, 32'h2762_7627);
    align_req <= 1'b1;
    repeat (70) @(posedge clk_i);
    align_req <= 1'b0;
    wb(0, ACTIVE_FREQ_OFS, 0);
    check(rd, 32'hD89D_89D9);
  endtask : t_retune
  // real, complex and quarter-rate modes over every decimation code
  task automatic t_rates;
    logic [31:0] c;
    int e;
    for (int m = 0; m < 3; m++) begin
      for (int k = 0; k < 8; k++) begin
        e = k < 1 ? 1 : (k > 5 ? 5 : k);
        c = 32'h0000_0101 | (m == 0 ? 32'h2 : m == 2 ? 32'h4 : 32'h0) | (k << 12);
        wb(1, CTRL_OFS, c);
        repeat (40) @(posedge clk_i);
        count_valid(64);
        check(n, (64 >> e) * (m == 2 ? 2 : 1));
      end
    end
  endtask : t_rates
  task automatic t_values;
    lvl_a <= 16'h1233;
    lvl_b <= 16'h0453;
    wb(1, CTRL_OFS, 32'h0000_230B);
    repeat (20) @(posedge clk_i);
    wait_valid();
    check({data_o.a.i, data_o.b.i}, 32'h0450_1230);
    check({data_o.a.q, data_o.b.q}, 32'h0000_0000);
    wb(1, FREQ_OFS, 32'h0000_0000);
    wb(1, CTRL_OFS, 32'h0000_2001);
    repeat (20) @(posedge clk_i);
    wait_valid();
    check({data_o.a.q, data_o.b.q}, 32'h0000_0000);
    check({data_o.a.i, data_o.b.i}, 32'h1228_0450);
    wb(1, CTRL_OFS, 32'h0000_2011);
    repeat (20) @(posedge clk_i);
    wait_valid();
    check({data_o.a.i, data_o.b.i}, 32'h2450_08A0);
    wb(1, CTRL_OFS, 32'h0000_2023);
    repeat (20) @(posedge clk_i);
    wait_valid();
    check({data_o.a.i, data_o.b.i}, 32'h1996_0613);
  endtask : t_values
  initial begin
    failures = 0;
    comparisons = 0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 4'h0;
    dat_i = 32'h0000_0000;
    align_req = 1'b0;
    lvl_a = 16'h0100;
    lvl_b = 16'hFF00;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_bypass();
    t_retune();
    t_rates();
    t_values();
    test_done();
  end
endmodule : down_converter_test
